// ---- hw/ext_bus_defs.svh ----
// Offsets, field positions, reset values and timing counts of the
// external bus release and wait control block.
// Assumes a 20 MHz system clock and a byte-addressed register bus.
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define OFS_BUS_CTL 4'h0
`define OFS_BUS_STATUS 4'h4

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTL_RELEASE_EN_BIT 15
`define CTL_REQ_OUT_EN_BIT 14
`define CTL_WBUF_EN_BIT 9
`define CTL_WAIT_EN_BIT 8
`define CTL_RESET 16'h0000
`define CTL_WRITE_MASK 16'hc300

// ****************************************************************
// Status register fields
// ****************************************************************
`define STS_RELEASED_BIT 0
`define STS_REQ_OUT_BIT 1
`define STS_BUSY_BIT 2
`define STS_WAITING_BIT 3
`define STS_BUFFERED_BIT 4

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ 20
`define ACC_TIME_NS 100
`define ACC_CYCLES ((`ACC_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

// ---- hw/ext_bus_pkg.sv ----
// Types of the external bus release and wait control block.
// Assumes ext_bus_defs.svh is on the include path.
`include "ext_bus_defs.svh"

package ext_bus_pkg;

   // ****************************************************************
   // External bus sequencer states
   // ****************************************************************
   typedef enum logic [2:0]
   {
      BUS_IDLE = 3'b001,
      BUS_CYCLE = 3'b010,
      BUS_RELEASED = 3'b100
   } bus_state_t;

   // ****************************************************************
   // Whole state of the top module
   // ****************************************************************
   typedef struct packed
   {
      logic [15:0] ctl;
      bus_state_t state;
      logic [3:0] cnt;
      logic [23:0] addr;
      logic [15:0] wdata;
      logic write;
      logic buffered;
      logic [15:0] acc_rdata;
      logic av_ack;
      logic [31:0] av_rdata;
   } ctl_state_t;

endpackage : ext_bus_pkg

// ---- hw/pin_mux_if.sv ----
// Carrier between the controller and one shared pin multiplexer.
// Assumes both ends sit in the same clock domain.
interface pin_mux_if;
   logic fn_en;
   logic fn_drive;
   logic port_data;
   logic port_dir;
   logic pin_o;
   logic pin_oe;

   modport mux
   (
      input fn_en,
      input fn_drive,
      input port_data,
      input port_dir,
      output pin_o,
      output pin_oe
   );

   modport ctl
   (
      output fn_en,
      output fn_drive,
      output port_data,
      output port_dir,
      input pin_o,
      input pin_oe
   );
endinterface : pin_mux_if

// ---- hw/pin_mux.sv ----
// Hands one output-capable pin either to a bus function or back to
// its general-purpose port settings.
// Assumes the port data and direction come from the port registers.
module pin_mux
(
   pin_mux_if.mux pm
);

   // Function owns the pin outright; otherwise port settings apply
   always_comb
   begin
      if (pm.fn_en)
      begin
         pm.pin_o = pm.fn_drive;
         pm.pin_oe = 1'b1;
      end
      else
      begin
         pm.pin_o = pm.port_data;
         pm.pin_oe = pm.port_dir;
      end
   end

endmodule : pin_mux

// ---- hw/ext_bus_ctl.sv ----
// External bus control: release to an outside master, request
// output, buffered writes and wait-state input, with a register bank
// on an Avalon-MM slave port.
// Assumes all inputs are synchronous to CLK_IN and the pins are
// active low at the chip boundary.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`include "ext_bus_defs.svh"

// How it works
// - Control bit 15 decides whether an outside request for the bus is ever granted.
// - With release disabled the request input and grant and request outputs belong to the port.
// - With bits 15 and 14 set, a pending internal access while released drives the request output.
// - With bit 14 clear the request output pin stays under port control.
// - Bit 9 makes external writes go through the write buffer, acknowledged at once.
// - A new buffer setting is picked up only when a later access starts.
// - Bit 8 makes the wait pin stretch external accesses; otherwise it is ignored.
// - With wait input disabled the wait pin is left to the port.
// - Bits 13 to 12 and 5 to 0 read zero and ignore writes.
// - Bits 11 to 10 and 7 to 6 read zero and software writes zero to them.
module ext_bus_ctl
(
   input wire logic CLK_IN,
   input wire logic RESET_IN,
   input wire logic [3:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic ACC_REQ_IN,
   input wire logic ACC_WRITE_IN,
   input wire logic [23:0] ACC_ADDR_IN,
   input wire logic [15:0] ACC_WDATA_IN,
   output logic ACC_READY_OUT,
   output logic [15:0] ACC_RDATA_OUT,
   output logic [23:0] EXT_ADDR_OUT,
   output logic [15:0] EXT_DATA_OUT,
   input wire logic [15:0] EXT_DATA_IN,
   output logic EXT_DATA_OE_OUT,
   output logic EXT_BUS_OE_OUT,
   output logic EXT_CS_N_OUT,
   output logic EXT_WE_N_OUT,
   input wire logic WAIT_N_IN,
   output logic WAIT_PIN_FN_OUT,
   input wire logic BUS_REQUEST_INPUT_N_IN,
   output logic REQ_PIN_FN_OUT,
   input wire logic GRANT_PORT_DATA_IN,
   input wire logic GRANT_PORT_DIR_IN,
   output logic GRANT_PIN_OUT,
   output logic GRANT_PIN_OE_OUT,
   input wire logic REQOUT_PORT_DATA_IN,
   input wire logic REQOUT_PORT_DIR_IN,
   output logic BUS_REQUEST_OUTPUT_PIN_OUT,
   output logic BUS_REQUEST_OUTPUT_PIN_OE_OUT
);

   // ****************************************************************
   // State
   // ****************************************************************
   ext_bus_pkg::ctl_state_t st_reg;
   ext_bus_pkg::ctl_state_t st_next;

   logic bus_release_enable;
   logic request_output_pin_enable;
   logic write_buffer_enable;
   logic wait_input_enable;
   logic ext_request;
   logic wait_active;
   logic in_cycle;
   logic in_released;
   logic last_state;
   logic cycle_done;
   logic start_access;
   logic start_buffered;
   logic bus_request_output;
   logic av_req;
   logic av_read_phase;
   logic av_commit;
   logic [15:0] status_word;
   logic [15:0] wr_merged;

   pin_mux_if grant_if ();
   pin_mux_if reqout_if ();

   // ****************************************************************
   // Control fields
   // ****************************************************************
   assign bus_release_enable = st_reg.ctl[`CTL_RELEASE_EN_BIT];
   assign request_output_pin_enable = st_reg.ctl[`CTL_REQ_OUT_EN_BIT];
   assign write_buffer_enable = st_reg.ctl[`CTL_WBUF_EN_BIT];
   assign wait_input_enable = st_reg.ctl[`CTL_WAIT_EN_BIT];

   // ****************************************************************
   // Pin sampling
   // ****************************************************************
   // The request input starts a release only while release is enabled
   assign ext_request = bus_release_enable & ~BUS_REQUEST_INPUT_N_IN;
   // The wait pin is looked at only while wait input is enabled
   assign wait_active = wait_input_enable & ~WAIT_N_IN;

   assign in_cycle = (st_reg.state == ext_bus_pkg::BUS_CYCLE);
   assign in_released = (st_reg.state == ext_bus_pkg::BUS_RELEASED);
   assign last_state = in_cycle & (st_reg.cnt == 4'h0);
   // Wait pin is sampled in the last state of each access
   assign cycle_done = last_state & ~wait_active;

   // ****************************************************************
   // Access sequencing decisions
   // ****************************************************************
   // An idle bus goes to the outside master before a new access starts
   assign start_access = (st_reg.state == ext_bus_pkg::BUS_IDLE) &
      ~ext_request & ACC_REQ_IN;
   // Buffer setting is read only here, at the start of an access
   assign start_buffered = start_access & ACC_WRITE_IN &
      write_buffer_enable;

   // ****************************************************************
   // Request towards the outside master while the bus is out
   // ****************************************************************
   assign bus_request_output = in_released & ACC_REQ_IN &
      request_output_pin_enable;

   // ****************************************************************
   // Register bus decode
   // ****************************************************************
   assign av_req = AVS_READ_IN | AVS_WRITE_IN;
   // First cycle of a request loads read data; second cycle answers
   assign av_read_phase = AVS_READ_IN & ~st_reg.av_ack;
   assign av_commit = AVS_WRITE_IN & st_reg.av_ack;

   always_comb
   begin
      status_word = 16'h0000;
      status_word[`STS_RELEASED_BIT] = in_released;
      status_word[`STS_REQ_OUT_BIT] = bus_request_output;
      status_word[`STS_BUSY_BIT] = in_cycle;
      status_word[`STS_WAITING_BIT] = last_state & wait_active;
      status_word[`STS_BUFFERED_BIT] = in_cycle & st_reg.buffered;
   end

   // Only the enable bits take write data; every reserved bit is 0
   assign wr_merged = (st_reg.ctl & ~`CTL_WRITE_MASK) |
      (AVS_WRITEDATA_IN[15:0] & `CTL_WRITE_MASK);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      st_next = st_reg;

      // Register bus: one wait cycle per request
      st_next.av_ack = av_req & ~st_reg.av_ack;
      if (av_read_phase)
      begin
         unique case (AVS_ADDRESS_IN)
            `OFS_BUS_CTL:
            begin
               st_next.av_rdata = {16'h0000,
                  st_reg.ctl & `CTL_WRITE_MASK};
            end
            `OFS_BUS_STATUS:
            begin
               st_next.av_rdata = {16'h0000, status_word};
            end
            default:
            begin
               st_next.av_rdata = 32'h0000_0000;
            end
         endcase
      end

      // All writable bits live in byte lane 1
      if (av_commit && AVS_ADDRESS_IN == `OFS_BUS_CTL &&
         AVS_BYTEENABLE_IN[1])
      begin
         st_next.ctl = wr_merged;
      end

      // External bus sequencer
      unique case (st_reg.state)
         ext_bus_pkg::BUS_IDLE:
         begin
            if (ext_request)
            begin
               st_next.state = ext_bus_pkg::BUS_RELEASED;
            end
            else if (ACC_REQ_IN)
            begin
               st_next.state = ext_bus_pkg::BUS_CYCLE;
               st_next.cnt = 4'(`ACC_CYCLES - 1);
               st_next.addr = ACC_ADDR_IN;
               st_next.wdata = ACC_WDATA_IN;
               st_next.write = ACC_WRITE_IN;
               st_next.buffered = start_buffered;
            end
         end
         ext_bus_pkg::BUS_CYCLE:
         begin
            if (st_reg.cnt != 4'h0)
            begin
               st_next.cnt = st_reg.cnt - 4'h1;
            end
            else if (cycle_done)
            begin
               // A held wait pin keeps the sequencer here
               st_next.state = ext_bus_pkg::BUS_IDLE;
               st_next.buffered = 1'b0;
               if (!st_reg.write)
               begin
                  st_next.acc_rdata = EXT_DATA_IN;
               end
            end
         end
         ext_bus_pkg::BUS_RELEASED:
         begin
            // Bus comes back only when the outside master lets go,
            // even if software clears the release enable meanwhile
            if (BUS_REQUEST_INPUT_N_IN)
            begin
               st_next.state = ext_bus_pkg::BUS_IDLE;
            end
         end
         default:
         begin
            st_next.state = ext_bus_pkg::BUS_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         st_reg <= '{ctl: `CTL_RESET,
                     state: ext_bus_pkg::BUS_IDLE,
                     cnt: 4'h0,
                     addr: 24'h00_0000,
                     wdata: 16'h0000,
                     write: 1'b0,
                     buffered: 1'b0,
                     acc_rdata: 16'h0000,
                     av_ack: 1'b0,
                     av_rdata: 32'h0000_0000};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ****************************************************************
   // Register bus outputs
   // ****************************************************************
   assign AVS_WAITREQUEST_OUT = av_req & ~st_reg.av_ack;
   assign AVS_READDATA_OUT = st_reg.av_rdata;

   // ****************************************************************
   // Internal master answer
   // ****************************************************************
   // Buffered writes are answered on acceptance, the rest on completion
   assign ACC_READY_OUT = start_buffered |
      (cycle_done & ~st_reg.buffered);
   assign ACC_RDATA_OUT = st_reg.acc_rdata;

   // ****************************************************************
   // External bus outputs
   // ****************************************************************
   assign EXT_ADDR_OUT = st_reg.addr;
   assign EXT_DATA_OUT = st_reg.wdata;
   assign EXT_DATA_OE_OUT = in_cycle & st_reg.write;
   // Everything floats while the outside master owns the bus
   assign EXT_BUS_OE_OUT = ~in_released;
   assign EXT_CS_N_OUT = ~in_cycle;
   assign EXT_WE_N_OUT = ~(in_cycle & st_reg.write);

   // ****************************************************************
   // Pin ownership
   // ****************************************************************
   assign REQ_PIN_FN_OUT = bus_release_enable;
   assign WAIT_PIN_FN_OUT = wait_input_enable;

   assign grant_if.fn_en = bus_release_enable;
   assign grant_if.fn_drive = ~in_released;
   assign grant_if.port_data = GRANT_PORT_DATA_IN;
   assign grant_if.port_dir = GRANT_PORT_DIR_IN;

   // Request output pin needs both enables to leave the port
   assign reqout_if.fn_en = bus_release_enable &
      request_output_pin_enable;
   assign reqout_if.fn_drive = ~bus_request_output;
   assign reqout_if.port_data = REQOUT_PORT_DATA_IN;
   assign reqout_if.port_dir = REQOUT_PORT_DIR_IN;

   pin_mux grant_mux
   (
      .pm(grant_if.mux)
   );

   pin_mux reqout_mux
   (
      .pm(reqout_if.mux)
   );

   assign GRANT_PIN_OUT = grant_if.pin_o;
   assign GRANT_PIN_OE_OUT = grant_if.pin_oe;
   assign BUS_REQUEST_OUTPUT_PIN_OUT = reqout_if.pin_o;
   assign BUS_REQUEST_OUTPUT_PIN_OE_OUT = reqout_if.pin_oe;

endmodule : ext_bus_ctl

// ---- test/ext_side_model.sv ----
// Far side of the external bus: a memory that answers reads, a wait
// source and an outside master that asks for the bus.
// Assumes all controller pins change on rising edges of clk_in.
module ext_side_model
(
   input wire logic clk_in,
   input wire logic cs_n_in,
   input wire logic [23:0] addr_in,
   input wire logic want_bus_in,
   input wire logic [3:0] n_wait_in,
   output logic [15:0] rdata_out,
   output logic wait_n_out,
   output logic bus_request_input_n_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int k = 0;
   logic [15:0] junk_reg = 16'h0000;
   always @(posedge clk_in)
   begin
      k <= cs_n_in ? 0 : k + 1;
      junk_reg <= ~junk_reg;
   end
   // Deselected bus shows a changing pattern, so no stale value passes
   assign rdata_out = cs_n_in ? junk_reg : addr_in[15:0] ^ 16'h5a5a;
   // Low from the last base state on, for n_wait_in cycles
   assign wait_n_out = !(!cs_n_in && k >= 1 && k < 1 + n_wait_in);
   assign bus_request_input_n_out = !want_bus_in;
endmodule : ext_side_model

// ---- test/ext_bus_ctl_chk.sv ----
// Concurrent checks on the ports of the external bus controller.
// Assumes one clock domain and an asynchronous active-high reset.
module ext_bus_ctl_chk
(
   input wire logic CLK_IN, RESET_IN, AVS_READ_IN, AVS_WRITE_IN,
   input wire logic [3:0] AVS_ADDRESS_IN, AVS_BYTEENABLE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN, AVS_READDATA_OUT,
   input wire logic AVS_WAITREQUEST_OUT, ACC_REQ_IN, ACC_WRITE_IN,
   input wire logic ACC_READY_OUT, EXT_BUS_OE_OUT, EXT_CS_N_OUT,
   input wire logic EXT_WE_N_OUT, WAIT_N_IN, WAIT_PIN_FN_OUT,
   input wire logic BUS_REQUEST_INPUT_N_IN, REQ_PIN_FN_OUT,
   input wire logic GRANT_PORT_DATA_IN, GRANT_PORT_DIR_IN,
   input wire logic GRANT_PIN_OUT, GRANT_PIN_OE_OUT,
   input wire logic REQOUT_PORT_DATA_IN, REQOUT_PORT_DIR_IN,
   input wire logic BUS_REQUEST_OUTPUT_PIN_OUT,
   input wire logic BUS_REQUEST_OUTPUT_PIN_OE_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   // Writable control bits rebuilt from committed bus writes
   logic [15:0] ctl_copy_reg;
   always_ff @(posedge CLK_IN or posedge RESET_IN)
      if (RESET_IN)
         ctl_copy_reg <= 16'h0000;
      else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT &&
               AVS_ADDRESS_IN == 4'h0 && AVS_BYTEENABLE_IN[1])
         ctl_copy_reg <= AVS_WRITEDATA_IN[15:0] & 16'hc300;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RESET_IN);
   rel_gate_a:
   assert property (!REQ_PIN_FN_OUT && EXT_BUS_OE_OUT |=> EXT_BUS_OE_OUT)
      else $error("bus released while release disabled");
   rel_take_a:
   assert property (REQ_PIN_FN_OUT && EXT_CS_N_OUT && !BUS_REQUEST_INPUT_N_IN
      |=> !EXT_BUS_OE_OUT && GRANT_PIN_OE_OUT && !GRANT_PIN_OUT)
      else $error("outside request not granted");
   pins_port_a:
   assert property (!REQ_PIN_FN_OUT && EXT_BUS_OE_OUT |->
      GRANT_PIN_OUT == GRANT_PORT_DATA_IN && GRANT_PIN_OE_OUT ==
      GRANT_PORT_DIR_IN) else $error("grant pin not under port control");
   reqout_on_a:
   assert property (ctl_copy_reg[14] && REQ_PIN_FN_OUT && !EXT_BUS_OE_OUT &&
      ACC_REQ_IN |-> BUS_REQUEST_OUTPUT_PIN_OE_OUT &&
      !BUS_REQUEST_OUTPUT_PIN_OUT) else $error("request output not driven");
   reqout_port_a:
   assert property (!ctl_copy_reg[14] |-> BUS_REQUEST_OUTPUT_PIN_OUT ==
      REQOUT_PORT_DATA_IN && BUS_REQUEST_OUTPUT_PIN_OE_OUT ==
      REQOUT_PORT_DIR_IN) else $error("request output pin not port");
   buf_write_a:
   assert property (ACC_READY_OUT && EXT_CS_N_OUT |-> ACC_WRITE_IN &&
      ctl_copy_reg[9] ##1 !EXT_CS_N_OUT && !EXT_WE_N_OUT)
      else $error("early ready without buffered write");
   wait_off_a:
   assert property ($fell(EXT_CS_N_OUT) && EXT_WE_N_OUT && !WAIT_PIN_FN_OUT
      |=> ACC_READY_OUT) else $error("read not done in base time");
   wait_fn_a:
   assert property (WAIT_PIN_FN_OUT == ctl_copy_reg[8] &&
      REQ_PIN_FN_OUT == ctl_copy_reg[15]) else $error("pin owner wrong");
   wait_hold_a:
   assert property (!EXT_CS_N_OUT && WAIT_PIN_FN_OUT && !WAIT_N_IN
      |=> !EXT_CS_N_OUT) else $error("access ended while wait held");
   wait_ready_a:
   assert property (ACC_READY_OUT && !EXT_CS_N_OUT && WAIT_PIN_FN_OUT
      |-> WAIT_N_IN) else $error("ready during wait");
   ctl_read_a:
   assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN ==
      4'h0 |-> AVS_READDATA_OUT == {16'h0000, ctl_copy_reg})
      else $error("control readback wrong");
   cover property ($fell(EXT_BUS_OE_OUT));
   cover property (ACC_READY_OUT && EXT_CS_N_OUT);
   cover property (!EXT_CS_N_OUT && !WAIT_N_IN && WAIT_PIN_FN_OUT);
   cover property (BUS_REQUEST_OUTPUT_PIN_OE_OUT && ctl_copy_reg[14]);
endmodule : ext_bus_ctl_chk

bind ext_bus_ctl ext_bus_ctl_chk chk (.*);

// ---- test/test_ext_bus_release_wait_control.sv ----
// Self-checking bench of the external bus release and wait control.
// Assumes the design, the far-side model and the checker compile first.
module test_ext_bus_release_wait_control;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // Signals
   // ****************
   localparam int ACC_N = 2;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [3:0] av_addr = 4'h0;
   logic [3:0] av_be = 4'h0;
   logic [31:0] av_wdata = 32'h0;
   logic acc_req = 1'b0;
   logic acc_wr = 1'b0;
   logic [23:0] acc_addr = 24'h0;
   logic [15:0] acc_wdata = 16'h0;
   logic [3:0] port_pins = 4'h0;
   logic want_bus = 1'b0;
   logic [3:0] n_wait = 4'h0;
   logic [31:0] av_rdata, q, d;
   logic [15:0] acc_rdata, ext_dout, ext_din;
   logic [23:0] ext_addr;
   logic av_wait, acc_rdy, ext_doe, bus_oe, cs_n, we_n, wait_n, wait_fn;
   logic bus_request_input_n, req_fn, grant, grant_oe, rq, rq_oe;
   int seed = 32'hc58f;
   int failures = 0;
   int n_compared = 0;
   int ctl_m = 0;
   int lat;
   always #25 clk = ~clk;
   always @(posedge clk)
      port_pins <= 4'($random(seed));
   ext_bus_ctl dut
   (
      .CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(av_addr),
      .AVS_READ_IN(av_rd), .AVS_WRITE_IN(av_wr), .AVS_WRITEDATA_IN(av_wdata),
      .AVS_BYTEENABLE_IN(av_be), .AVS_READDATA_OUT(av_rdata),
      .AVS_WAITREQUEST_OUT(av_wait), .ACC_REQ_IN(acc_req),
      .ACC_WRITE_IN(acc_wr), .ACC_ADDR_IN(acc_addr),
      .ACC_WDATA_IN(acc_wdata), .ACC_READY_OUT(acc_rdy),
      .ACC_RDATA_OUT(acc_rdata), .EXT_ADDR_OUT(ext_addr),
      .EXT_DATA_OUT(ext_dout), .EXT_DATA_IN(ext_din),
      .EXT_DATA_OE_OUT(ext_doe), .EXT_BUS_OE_OUT(bus_oe),
      .EXT_CS_N_OUT(cs_n), .EXT_WE_N_OUT(we_n), .WAIT_N_IN(wait_n),
      .WAIT_PIN_FN_OUT(wait_fn), .BUS_REQUEST_INPUT_N_IN(bus_request_input_n),
      .REQ_PIN_FN_OUT(req_fn), .GRANT_PORT_DATA_IN(port_pins[3]),
      .GRANT_PORT_DIR_IN(port_pins[2]), .GRANT_PIN_OUT(grant),
      .GRANT_PIN_OE_OUT(grant_oe), .REQOUT_PORT_DATA_IN(port_pins[1]),
      .REQOUT_PORT_DIR_IN(port_pins[0]), .BUS_REQUEST_OUTPUT_PIN_OUT(rq),
      .BUS_REQUEST_OUTPUT_PIN_OE_OUT(rq_oe)
   );
   ext_side_model far
   (
      .clk_in(clk), .cs_n_in(cs_n), .addr_in(ext_addr),
      .want_bus_in(want_bus), .n_wait_in(n_wait), .rdata_out(ext_din),
      .wait_n_out(wait_n), .bus_request_input_n_out(bus_request_input_n)
   );
   // ****************
   // Tasks
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic av(input logic w, input logic [3:0] a,
      input logic [31:0] dw, input logic [3:0] be, output logic [31:0] r);
      @(posedge clk);
      av_rd <= !w;
      av_wr <= w;
      av_addr <= a;
      av_wdata <= dw;
      av_be <= be;
      // Waitrequest and read data are taken at the same rising edge
      @(posedge clk);
      while (av_wait !== 1'b0)
         @(posedge clk);
      r = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask : av
   task automatic setc(input logic [31:0] dw);
      logic [31:0] r;
      av(1'b1, 4'h0, dw, 4'hf, r);
   endtask : setc
   task automatic acc(input logic w, input logic [23:0] a,
      input logic [15:0] dw, output int n);
      logic late;
      n = 0;
      @(posedge clk);
      acc_req <= 1'b1;
      acc_wr <= w;
      acc_addr <= a;
      acc_wdata <= dw;
      @(negedge clk);
      while (acc_rdy !== 1'b1)
      begin
         n++;
         @(negedge clk);
      end
      // A buffered write shows on the pins only after the request drops
      late = (cs_n !== 1'b0);
      if (late)
      begin
         @(posedge clk);
         acc_req <= 1'b0;
         @(negedge clk);
      end
      if (w)
      begin
         check({ext_doe, we_n, ext_addr}, {2'b10, a});
         check(ext_dout, dw);
      end
      if (!late)
      begin
         @(posedge clk);
         acc_req <= 1'b0;
      end
   endtask : acc
   task automatic results();
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // ****************
   // Tests
   // ****************
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      av(1'b0, 4'h0, 32'h0, 4'hf, q);
      check(q, 32'h0);
      av(1'b0, 4'h8, 32'h0, 4'hf, q);
      check(q, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 8; i++)
      begin
         // Last two writes miss: unmapped address, then lane 1 off
         d = $random(seed) & 32'h0000f33f;
         av(1'b1, (i == 6) ? 4'hc : 4'h0, d, (i == 7) ? 4'hd : 4'hf, q);
         if (i < 6)
            ctl_m = d & 32'hc300;
         av(1'b0, 4'h0, 32'h0, 4'hf, q);
         check(q, ctl_m);
      end
      $display("register test done");
      n_wait <= 4'h3;
      for (int e = 0; e < 2; e++)
      begin
         // Input buffers of the pins are taken as set beforehand
         setc(e ? 32'h100 : 32'h0);
         d = $random(seed);
         acc(1'b0, d[23:0], 16'h0, lat);
         check(lat, ACC_N + (e ? 3 : 0));
         @(negedge clk);
         check(acc_rdata, d[15:0] ^ 16'h5a5a);
      end
      for (int b = 0; b < 2; b++)
      begin
         setc(b ? 32'h200 : 32'h0);
         d = $random(seed);
         acc(1'b1, d[23:0], d[31:16], lat);
         check(lat, b ? 0 : ACC_N);
      end
      $display("access test done");
      setc(32'h0);
      want_bus <= 1'b1;
      repeat (3) @(negedge clk);
      check({bus_oe, grant, grant_oe}, {1'b1, port_pins[3:2]});
      setc(32'h8000);
      repeat (2) @(negedge clk);
      check({bus_oe, grant_oe, grant}, 3'b010);
      fork
         acc(1'b0, 24'h000123, 16'h0, lat);
         begin
            repeat (3) @(negedge clk);
            check({rq, rq_oe, acc_rdy}, {port_pins[1:0], 1'b0});
            setc(32'hc000);
            @(negedge clk);
            check({rq, rq_oe}, 2'b01);
            // Status shows the bus out and the request output active
            av(1'b0, 4'h4, 32'h0, 4'hf, q);
            check(q, 32'h0000_0003);
            @(posedge clk);
            want_bus <= 1'b0;
         end
      join
      @(negedge clk);
      check({bus_oe, acc_rdata}, {1'b1, 16'h0123 ^ 16'h5a5a});
      $display("release test done");
      results();
   end
   initial
   begin
      #100000;
      failures++;
      results();
   end
endmodule : test_ext_bus_release_wait_control
